//--- hdl/spcg_defs.svh
`ifndef SPCG_DEFS_SVH
`define SPCG_DEFS_SVH

// Register byte offsets
`define SPCG_OFF_SYS_ENABLE 8'h00
`define SPCG_OFF_SYS_DISABLE 8'h04
`define SPCG_OFF_SYS_STATE 8'h08
`define SPCG_OFF_PER_ENABLE 8'h10
`define SPCG_OFF_PER_DISABLE 8'h14
`define SPCG_OFF_PER_STATE 8'h18
`define SPCG_OFF_OSC_CONTROL 8'h20
`define SPCG_OFF_OSC_STATUS 8'h68

// System clock register fields
`define SPCG_BIT_CPU 0
`define SPCG_BIT_USB 7
`define SPCG_BIT_PROG_LO 8
`define SPCG_BIT_PROG_HI 10

// Oscillator control fields, and the stable bit of the oscillator status register
`define SPCG_BIT_OSC_ENABLE 0
`define SPCG_BIT_OSC_BYPASS 1
`define SPCG_BIT_OSC_COUNT_LO 8
`define SPCG_BIT_OSC_COUNT_HI 15
`define SPCG_BIT_OSC_STABLE 0

// Start-up count is in units of eight slow clock cycles
`define SPCG_OSC_SCALE_SHIFT 3

// Reset values
`define SPCG_RST_CPU 1'b1
`define SPCG_RST_USB 1'b0
`define SPCG_RST_PROG 3'h0
`define SPCG_RST_PERIPH 32'h0000_0000
`define SPCG_RST_OSC_COUNT 8'h00

// Identifiers 0 and 1 have no gate
`define SPCG_PERIPH_MASK 32'hFFFF_FFFC

// Timing: core clock and slow clock rates in Hz
`define SPCG_CLK_HZ 125000000
`define SPCG_SLOW_CLK_HZ 32768

`endif

//--- hdl/spcg_pkg.sv
`include "spcg_defs.svh"

package spcg_pkg;

    typedef enum logic [1:0]
    {
        OSC_OFF = 2'b00,
        OSC_COUNT = 2'b01,
        OSC_READY = 2'b10,
        OSC_BYPASS = 2'b11
    } spcg_osc_state_type;

    typedef struct packed
    {
        logic cpu;
        logic usb;
        logic [2:0] prog;
        logic [31:0] periph;
        logic osc_en;
        logic osc_byp;
        logic [7:0] osc_cnt;
        logic osc_restart;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } spcg_state_type;

    typedef struct packed
    {
        spcg_osc_state_type mode;
        logic [15:0] div;
        logic [10:0] count;
        logic stable;
    } spcg_osc_reg_type;

endpackage : spcg_pkg

//--- hdl/spcg_osc_if.sv
interface spcg_osc_if;
    logic enable;
    logic bypass;
    logic restart;
    logic [7:0] startup_count;
    logic stable;

    modport ctrl
    (
        output enable,
        output bypass,
        output restart,
        output startup_count,
        input stable
    );

    modport osc
    (
        input enable,
        input bypass,
        input restart,
        input startup_count,
        output stable
    );
endinterface : spcg_osc_if

//--- hdl/spcg_osc_startup.sv
`include "spcg_defs.svh"

module spcg_osc_startup
#(
    parameter int SLOW_DIV = `SPCG_CLK_HZ / `SPCG_SLOW_CLK_HZ
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Oscillator control
    spcg_osc_if.osc osc_port
);
    import spcg_pkg::*;

    spcg_osc_reg_type cur;
    spcg_osc_reg_type next_cur;

    always_comb
    begin
        logic tick;
        logic [10:0] target;
        tick = 1'b0;
        target = 11'({3'h0, osc_port.startup_count} << `SPCG_OSC_SCALE_SHIFT);
        next_cur = cur;
        // Slow clock enable pulse
        if (cur.div == 16'(SLOW_DIV - 1))
        begin
            next_cur.div = 16'h0000;
            tick = 1'b1;
        end
        else
        begin
            next_cur.div = cur.div + 16'h0001;
        end
        if (osc_port.bypass)
        begin
            next_cur.mode = OSC_BYPASS;
            next_cur.stable = 1'b1;
        end
        else if (!osc_port.enable)
        begin
            next_cur.mode = OSC_OFF;
            next_cur.stable = 1'b0;
            next_cur.count = 11'h000;
        end
        else if (osc_port.restart || cur.mode == OSC_OFF || cur.mode == OSC_BYPASS)
        begin
            next_cur.mode = OSC_COUNT;
            next_cur.stable = 1'b0;
            next_cur.count = 11'h000;
        end
        else
        begin
            case (cur.mode)
                OSC_COUNT:
                begin
                    // wait count times eight slow cycles
                    if (cur.count >= target)
                    begin
                        next_cur.mode = OSC_READY;
                        next_cur.stable = 1'b1;
                    end
                    else if (tick)
                    begin
                        next_cur.count = cur.count + 11'h001;
                    end
                end
                OSC_READY:
                begin
                    next_cur.stable = 1'b1;
                end
                default:
                begin
                    next_cur.mode = OSC_OFF;
                    next_cur.stable = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cur <= '{mode: OSC_OFF, div: 16'h0000, count: 11'h000, stable: 1'b0};
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign osc_port.stable = cur.stable;

endmodule : spcg_osc_startup

//--- hdl/spcg_clock_gating.sv
// Decided for this implementation: the register offsets and the APB interface to the registers.
`include "spcg_defs.svh"

module spcg_clock_gating
#(
    parameter int SLOW_DIV = `SPCG_CLK_HZ / `SPCG_SLOW_CLK_HZ,
    parameter logic [31:0] PERIPH_IMPL = `SPCG_PERIPH_MASK
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Gate enables
    output logic cpu_clock_gate_out,
    output logic usb_device_clock_gate_out,
    output logic [2:0] programmable_output_gate_out,
    output logic [31:0] peripheral_gate_bit_out,
    // Main oscillator
    output logic main_osc_enable_out,
    output logic main_osc_bypass_out,
    output logic main_osc_stable_flag_out
);
    import spcg_pkg::*;

    spcg_state_type cur;
    spcg_state_type next_cur;
    logic stable_q;
    logic next_stable_q;

    spcg_osc_if osc_link();

    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        reg_hit = (addr[7:2] == off[7:2]);
    endfunction : reg_hit

    function automatic logic reg_mapped(input logic [7:0] addr);
        reg_mapped = reg_hit(addr, `SPCG_OFF_SYS_ENABLE) || reg_hit(addr, `SPCG_OFF_SYS_DISABLE)
            || reg_hit(addr, `SPCG_OFF_SYS_STATE) || reg_hit(addr, `SPCG_OFF_PER_ENABLE)
            || reg_hit(addr, `SPCG_OFF_PER_DISABLE) || reg_hit(addr, `SPCG_OFF_PER_STATE)
            || reg_hit(addr, `SPCG_OFF_OSC_CONTROL) || reg_hit(addr, `SPCG_OFF_OSC_STATUS);
    endfunction : reg_mapped

    // Processor, USB and programmable gates as one word
    function automatic logic [31:0] sys_word(input spcg_state_type s);
        sys_word = 32'h0000_0000;
        sys_word[`SPCG_BIT_CPU] = s.cpu;
        sys_word[`SPCG_BIT_USB] = s.usb;
        sys_word[`SPCG_BIT_PROG_HI:`SPCG_BIT_PROG_LO] = s.prog;
    endfunction : sys_word

    function automatic logic [31:0] read_mux(input logic [7:0] addr, input spcg_state_type s,
        input logic stable);
        read_mux = 32'h0000_0000;
        if (reg_hit(addr, `SPCG_OFF_SYS_STATE))
        begin
            read_mux = sys_word(s);
        end
        else if (reg_hit(addr, `SPCG_OFF_PER_STATE))
        begin
            read_mux = s.periph;
        end
        else if (reg_hit(addr, `SPCG_OFF_OSC_CONTROL))
        begin
            read_mux[`SPCG_BIT_OSC_ENABLE] = s.osc_en;
            read_mux[`SPCG_BIT_OSC_BYPASS] = s.osc_byp;
            read_mux[`SPCG_BIT_OSC_COUNT_HI:`SPCG_BIT_OSC_COUNT_LO] = s.osc_cnt;
        end
        else if (reg_hit(addr, `SPCG_OFF_OSC_STATUS))
        begin
            read_mux[`SPCG_BIT_OSC_STABLE] = stable;
        end
        else
        begin
            read_mux = 32'h0000_0000;
        end
    endfunction : read_mux

    always_comb
    begin
        logic do_write;
        logic [31:0] wmask;
        do_write = 1'b0;
        wmask = 32'h0000_0000;
        next_cur = cur;
        next_cur.ready = 1'b0;
        next_cur.slverr = 1'b0;
        next_cur.osc_restart = 1'b0;
        // Access phase: answer one cycle after it opens
        if (psel_in && penable_in && !cur.ready)
        begin
            next_cur.ready = 1'b1;
            next_cur.slverr = !reg_mapped(paddr_in);
            if (!pwrite_in)
            begin
                next_cur.rdata = read_mux(paddr_in, cur, stable_q);
            end
        end
        // Write takes effect at the edge pready is seen high
        do_write = psel_in && penable_in && cur.ready && pwrite_in;
        if (do_write)
        begin
            if (reg_hit(paddr_in, `SPCG_OFF_SYS_ENABLE))
            begin
                next_cur.cpu = cur.cpu | pwdata_in[`SPCG_BIT_CPU];
                next_cur.usb = cur.usb | pwdata_in[`SPCG_BIT_USB];
                next_cur.prog = cur.prog | pwdata_in[`SPCG_BIT_PROG_HI:`SPCG_BIT_PROG_LO];
            end
            else if (reg_hit(paddr_in, `SPCG_OFF_SYS_DISABLE))
            begin
                next_cur.cpu = cur.cpu & ~pwdata_in[`SPCG_BIT_CPU];
                next_cur.usb = cur.usb & ~pwdata_in[`SPCG_BIT_USB];
                next_cur.prog = cur.prog & ~pwdata_in[`SPCG_BIT_PROG_HI:`SPCG_BIT_PROG_LO];
            end
            else if (reg_hit(paddr_in, `SPCG_OFF_PER_ENABLE))
            begin
                wmask = pwdata_in & PERIPH_IMPL & `SPCG_PERIPH_MASK;
                next_cur.periph = cur.periph | wmask;
            end
            else if (reg_hit(paddr_in, `SPCG_OFF_PER_DISABLE))
            begin
                wmask = pwdata_in & PERIPH_IMPL & `SPCG_PERIPH_MASK;
                next_cur.periph = cur.periph & ~wmask;
            end
            else if (reg_hit(paddr_in, `SPCG_OFF_OSC_CONTROL))
            begin
                // enable and bypass stored as written
                next_cur.osc_en = pwdata_in[`SPCG_BIT_OSC_ENABLE];
                next_cur.osc_byp = pwdata_in[`SPCG_BIT_OSC_BYPASS];
                next_cur.osc_cnt = pwdata_in[`SPCG_BIT_OSC_COUNT_HI:`SPCG_BIT_OSC_COUNT_LO];
                next_cur.osc_restart = pwdata_in[`SPCG_BIT_OSC_ENABLE] && !cur.osc_en;
            end
            else
            begin
                next_cur.osc_restart = 1'b0;
            end
        end
        next_stable_q = osc_link.stable;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            // only processor clock on after reset
            cur <= '{cpu: `SPCG_RST_CPU, usb: `SPCG_RST_USB, prog: `SPCG_RST_PROG,
                periph: `SPCG_RST_PERIPH, osc_en: 1'b0, osc_byp: 1'b0,
                osc_cnt: `SPCG_RST_OSC_COUNT, osc_restart: 1'b0,
                rdata: 32'h0000_0000, ready: 1'b0, slverr: 1'b0};
            stable_q <= 1'b0;
        end
        else
        begin
            cur <= next_cur;
            stable_q <= next_stable_q;
        end
    end

    assign osc_link.enable = cur.osc_en;
    assign osc_link.bypass = cur.osc_byp;
    assign osc_link.restart = cur.osc_restart;
    assign osc_link.startup_count = cur.osc_cnt;

    spcg_osc_startup #(
        .SLOW_DIV(SLOW_DIV)
    ) u_osc (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .osc_port(osc_link.osc)
    );

    assign prdata_out = cur.rdata;
    assign pready_out = cur.ready;
    assign pslverr_out = cur.slverr;
    // enables move after the rising edge, held through the low phase
    assign cpu_clock_gate_out = cur.cpu;
    assign usb_device_clock_gate_out = cur.usb;
    assign programmable_output_gate_out = cur.prog;
    assign peripheral_gate_bit_out = cur.periph;
    assign main_osc_enable_out = cur.osc_en;
    assign main_osc_bypass_out = cur.osc_byp;
    assign main_osc_stable_flag_out = stable_q;

endmodule : spcg_clock_gating

//--- bench/spcg_clock_gating_checker.sv
module spcg_clock_gating_checker
#(
    parameter logic [31:0] PERIPH_IMPL = 32'hFFFF_FFFC
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // APB
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic pready_out,
    // Gates and oscillator
    input wire logic cpu_clock_gate_out,
    input wire logic usb_device_clock_gate_out,
    input wire logic [2:0] programmable_output_gate_out,
    input wire logic [31:0] peripheral_gate_bit_out,
    input wire logic main_osc_stable_flag_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic wr;
    assign wr = psel_in && penable_in && pwrite_in && pready_out;
    sequence s_access;
        psel_in && penable_in && !pready_out;
    endsequence
    sequence s_sys_on;
        wr && paddr_in == 8'h00;
    endsequence
    sequence s_sys_off;
        wr && paddr_in == 8'h04;
    endsequence
    a_one_wait: assert property (s_access |=> pready_out) else $error("no answer after one wait state");
    a_ready_pulse: assert property (pready_out |=> !pready_out) else $error("ready longer than one cycle");
    a_cpu_on: assert property (s_sys_on ##0 pwdata_in[0] |=> cpu_clock_gate_out)
        else $error("cpu gate not set");
    a_usb_on: assert property (s_sys_on ##0 pwdata_in[7] |=> usb_device_clock_gate_out)
        else $error("usb gate not set");
    a_prog_on: assert property (s_sys_on |=>
        (programmable_output_gate_out & $past(pwdata_in[10:8])) == $past(pwdata_in[10:8]))
        else $error("output gate not set");
    a_cpu_off: assert property (s_sys_off ##0 pwdata_in[0] |=> !cpu_clock_gate_out)
        else $error("cpu gate not cleared");
    a_usb_off: assert property (s_sys_off ##0 pwdata_in[7] |=> !usb_device_clock_gate_out)
        else $error("usb gate not cleared");
    a_prog_off: assert property (s_sys_off |=> (programmable_output_gate_out & $past(pwdata_in[10:8])) == 3'h0)
        else $error("output gate not cleared");
    a_periph_on: assert property (wr && paddr_in == 8'h10 |=>
        (peripheral_gate_bit_out & $past(pwdata_in & PERIPH_IMPL)) == $past(pwdata_in & PERIPH_IMPL))
        else $error("peripheral gate not set");
    a_periph_off: assert property (wr && paddr_in == 8'h14 |=> (peripheral_gate_bit_out & $past(pwdata_in)) == 0)
        else $error("peripheral gate not cleared");
    a_pid_unused: assert property (peripheral_gate_bit_out[1:0] == 2'b00)
        else $error("unused peripheral gate set");
    a_gates_hold: assert property (!wr |=>
        $stable({cpu_clock_gate_out, usb_device_clock_gate_out, programmable_output_gate_out, peripheral_gate_bit_out}))
        else $error("gate changed without write");
    a_bypass_flag: assert property (wr && paddr_in == 8'h20 && pwdata_in[1] |-> ##3 main_osc_stable_flag_out)
        else $error("bypass did not raise stable");
    a_osc_off: assert property (wr && paddr_in == 8'h20 && pwdata_in[1:0] == 2'b00 |-> ##3 !main_osc_stable_flag_out)
        else $error("stable not cleared");
endmodule : spcg_clock_gating_checker

bind spcg_clock_gating spcg_clock_gating_checker #(.PERIPH_IMPL(PERIPH_IMPL)) chk (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .pready_out(pready_out),
    .cpu_clock_gate_out(cpu_clock_gate_out),
    .usb_device_clock_gate_out(usb_device_clock_gate_out),
    .programmable_output_gate_out(programmable_output_gate_out),
    .peripheral_gate_bit_out(peripheral_gate_bit_out),
    .main_osc_stable_flag_out(main_osc_stable_flag_out)
);

//--- bench/system_peripheral_clock_gating_bench.sv
module system_peripheral_clock_gating_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SLOW = 4;
    localparam logic [31:0] PIMPL = 32'hFFFF_FFFC;
    logic clk_in, rst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
    logic cpu_clock_gate_out, usb_device_clock_gate_out;
    logic main_osc_enable_out, main_osc_bypass_out, main_osc_stable_flag_out;
    logic [2:0] programmable_output_gate_out;
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, peripheral_gate_bit_out, lfsr, sysm, perm, rd, d;
    logic er;
    logic [7:0] addrs [4] = '{8'h00, 8'h04, 8'h10, 8'h14};
    int err_total = 0;
    int tests_run = 0;
    int n;

    spcg_clock_gating #(.SLOW_DIV(SLOW), .PERIPH_IMPL(PIMPL)) dut (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .psel_in(psel_in),
        .penable_in(penable_in),
        .pwrite_in(pwrite_in),
        .paddr_in(paddr_in),
        .pwdata_in(pwdata_in),
        .prdata_out(prdata_out),
        .pready_out(pready_out),
        .pslverr_out(pslverr_out),
        .cpu_clock_gate_out(cpu_clock_gate_out),
        .usb_device_clock_gate_out(usb_device_clock_gate_out),
        .programmable_output_gate_out(programmable_output_gate_out),
        .peripheral_gate_bit_out(peripheral_gate_bit_out),
        .main_osc_enable_out(main_osc_enable_out),
        .main_osc_bypass_out(main_osc_bypass_out),
        .main_osc_stable_flag_out(main_osc_stable_flag_out)
    );

    initial
    begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next

    // Set or clear the written ones, leave zeros alone
    function automatic logic [31:0] apply(input logic [31:0] m, input logic [31:0] v, input logic set);
        return set ? (m | v) : (m & ~v);
    endfunction : apply

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        int k = 0;
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= v;
        @(posedge clk_in);
        penable_in <= 1'b1;
        // Answer is taken at the rising edge where pready is seen high
        @(posedge clk_in);
        while (pready_out !== 1'b1 && k < 50)
        begin
            @(posedge clk_in);
            k++;
        end
        if (k >= 50)
            err_total++;
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask : apb

    task automatic check_all();
        chk("system gates", sysm, {21'h0, programmable_output_gate_out, usb_device_clock_gate_out, 6'h0,
            cpu_clock_gate_out});
        chk("peripheral gates", perm, peripheral_gate_bit_out);
        apb(1'b0, 8'h08, 32'h0);
        chk("system state", sysm, rd);
        apb(1'b0, 8'h18, 32'h0);
        chk("peripheral state", perm, rd);
    endtask : check_all

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    initial
    begin
        repeat (20000) @(posedge clk_in);
        err_total++;
        stop_test();
    end

    initial
    begin
        rst_n_in = 1'b0;
        psel_in = 1'b0;
        penable_in = 1'b0;
        pwrite_in = 1'b0;
        paddr_in = 8'h00;
        pwdata_in = 32'h0000_0000;
        lfsr = 32'h0000_005E;
        sysm = 32'h0000_0001;
        perm = 32'h0000_0000;
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        check_all();
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        apb(1'b1, 8'h08, 32'hFFFF_FFFF);
        check_all();
        for (int i = 0; i < 48; i++)
        begin
            lfsr = lfsr_next(lfsr);
            d = (i < 4) ? 32'hFFFF_FFFF : lfsr_next(lfsr);
            apb(1'b1, addrs[(i < 4) ? i[1:0] : lfsr[1:0]], d);
            if (i < 4 ? i[1] : lfsr[1])
                perm = apply(perm, d & PIMPL, !(i < 4 ? i[0] : lfsr[0]));
            else
                sysm = apply(sysm, d & 32'h0000_0781, !(i < 4 ? i[0] : lfsr[0]));
            check_all();
        end
        apb(1'b1, 8'h20, 32'h0000_0002);
        chk("oscillator bypass", 32'h1, {31'h0, main_osc_bypass_out});
        apb(1'b0, 8'h20, 32'h0);
        chk("oscillator control", 32'h0000_0002, rd);
        apb(1'b0, 8'h68, 32'h0);
        chk("bypass stable", 32'h1, {31'h0, rd[0]});
        chk("mapped error", 32'h0, {31'h0, er});
        apb(1'b1, 8'h20, 32'h0000_0000);
        apb(1'b0, 8'h68, 32'h0);
        chk("stable cleared", 32'h0, {31'h0, rd[0]});
        apb(1'b1, 8'h20, 32'h0000_0201);
        chk("oscillator enable", 32'h1, {31'h0, main_osc_enable_out});
        n = 2;
        while (main_osc_stable_flag_out !== 1'b1 && n < 300)
        begin
            @(negedge clk_in);
            n++;
        end
        chk("startup delay", 32'h1, {31'h0, n >= 2 * 8 * SLOW - 6 && n <= 2 * 8 * SLOW + 6});
        stop_test();
    end
endmodule : system_peripheral_clock_gating_bench
